// ---- ht_readout.sv ----
// Two-wire bus slave of the humidity and temperature sensor: measurement, result, NV registers.
// Assumes bus pins arrive asynchronously and the converter delivers samples on this clock.
//
// What this block does
// - A fetch is a read transfer; device acknowledges its address before result bytes.
// - Result bytes keep coming until the master NACKs and stops.
// - Bytes one and two carry humidity big-endian, status in the top two bits.
// - Bytes three and four carry temperature left-aligned; two low bits undefined.
// - Status 00 while the latest result has not been fetched.
// - Status 01 once fetched, and before the first measurement completes.
// - Programming mode entered only by A0 00 00 within the power-up window.
// - Programming-mode entry takes 120 us before registers are reachable.
// - Write 80 00 00 leaves programming mode.
// - Every non-volatile register is sixteen bits wide.
// - Resolution read at 06h/11h, written at 46h/51h.
// - Bits 11:10 pick 8/10/12/14 bits; both default to 14, independent.
// - Sensor identifier of 32 bits, upper at 1Eh and lower at 1Fh.
// - Address-only write transfer starts a measurement cycle.
// - Device answers only its fixed 7-bit address 44h.
// - Each finished cycle updates the result, then powers down.
`timescale 1ns/1ps
`default_nettype none

`include "ht_readout_map.svh"

module ht_readout #(
    parameter int unsigned WAKE_CYCLES = `HT_CYCLES(`HT_WAKE_US),
    parameter int unsigned CONV8_CYCLES = `HT_CYCLES(`HT_CONV8_US),
    parameter int unsigned CONV10_CYCLES = `HT_CYCLES(`HT_CONV10_US),
    parameter int unsigned CONV12_CYCLES = `HT_CYCLES(`HT_CONV12_US),
    parameter int unsigned CONV14_CYCLES = `HT_CYCLES(`HT_CONV14_US),
    parameter int unsigned WINDOW_CYCLES = `HT_CYCLES(`HT_PROG_WINDOW_US),
    parameter int FIFO_DEPTH = 8,
    // Arbitrary identifier value
    parameter logic [31:0] SENSOR_ID = 32'h1234_abcd,
    parameter logic [15:0] HUM_RES_INIT = `HT_RES_RESET,
    parameter logic [15:0] TEMP_RES_INIT = `HT_RES_RESET
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic scl,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    input wire logic sampleValid,
    output logic sampleReady,
    input wire logic [13:0] sampleHumidity,
    input wire logic [13:0] sampleTemperature,
    output logic measuring,
    output logic programmingMode
);
    import ht_readout_pkg::*;

    localparam int unsigned PROG_ENTRY_CYCLES = `HT_CYCLES(`HT_PROG_ENTRY_US);

    localparam state_s STATE_RESET = '{
        sclMeta: 1'b1, sclSync: 1'b1, sclPrev: 1'b1,
        sdaMeta: 1'b1, sdaSync: 1'b1, sdaPrev: 1'b1,
        phase: S_IDLE,
        humRes: HUM_RES_INIT,
        tempRes: TEMP_RES_INIT,
        default: '0
    };

    state_s r;
    state_s next_r;
    logic sclRise;
    logic sclFall;
    logic startCond;
    logic stopCond;
    logic fifoOutValid;
    logic fifoOutReady;
    logic [27:0] fifoOutData;
    logic measDone;
    logic [1:0] statusCode;
    logic fetchStart;

    // Conversion time of one quantity for a resolution code
    function automatic int unsigned convCycles(input logic [1:0] code);
        unique case (code)
            2'b00: convCycles = CONV8_CYCLES;
            2'b01: convCycles = CONV10_CYCLES;
            2'b10: convCycles = CONV12_CYCLES;
            2'b11: convCycles = CONV14_CYCLES;
        endcase
    endfunction

    // Whole cycle: wake-up plus both conversions
    function automatic logic [23:0] measCycles(input logic [15:0] hRes, input logic [15:0] tRes);
        measCycles = 24'(WAKE_CYCLES + convCycles(hRes[`HT_RES_MSB:`HT_RES_LSB])
            + convCycles(tRes[`HT_RES_MSB:`HT_RES_LSB]));
    endfunction

    // Byte of a read transfer at a given position
    function automatic logic [7:0] txByte(input state_s s, input logic [1:0] idx,
                                          input logic [1:0] status);
        if (s.progMode) begin
            txByte = idx[0] ? s.readback[7:0] : s.readback[15:8];
        end else begin
            unique case (idx)
                2'd0: txByte = {status, s.humidity[13:8]};
                2'd1: txByte = s.humidity[7:0];
                2'd2: txByte = s.temperature[13:6];
                2'd3: txByte = {s.temperature[5:0], 2'b00};
            endcase
        end
    endfunction

    ht_sample_fifo #(
        .WIDTH(28),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clock(clock),
        .srst(srst),
        .inValid(sampleValid),
        .inReady(sampleReady),
        .inData({sampleHumidity, sampleTemperature}),
        .outValid(fifoOutValid),
        .outReady(fifoOutReady),
        .outData(fifoOutData)
    );

    assign sclRise = r.sclSync && !r.sclPrev;
    assign sclFall = !r.sclSync && r.sclPrev;
    assign startCond = r.sclSync && r.sclPrev && r.sdaPrev && !r.sdaSync;
    assign stopCond = r.sclSync && r.sclPrev && !r.sdaPrev && r.sdaSync;
    // Converter is drained only when a cycle ends, so the FIFO can fill and stall it
    assign fifoOutReady = r.measBusy && (r.measCount == '0);
    assign measDone = fifoOutReady && fifoOutValid;
    assign statusCode = r.fresh ? `HT_STATUS_VALID : `HT_STATUS_STALE;
    assign fetchStart = (r.phase == S_ADDR_ACK) && sclFall && r.isRead && !r.progMode;
    assign sdaOut = 1'b0;
    assign sdaOe = r.sdaDrive;
    assign measuring = r.measBusy;
    assign programmingMode = r.progMode;

    always_comb begin
        logic [7:0] nextByte;
        next_r = r;
        nextByte = txByte(r, r.byteIndex, statusCode);
        next_r.sclMeta = scl;
        next_r.sclSync = r.sclMeta;
        next_r.sclPrev = r.sclSync;
        next_r.sdaMeta = sdaIn;
        next_r.sdaSync = r.sdaMeta;
        next_r.sdaPrev = r.sdaSync;
        if (r.winCount != 24'(WINDOW_CYCLES)) begin
            next_r.winCount = r.winCount + 24'd1;
        end
        if (r.progPending) begin
            if (r.progCount == 12'(PROG_ENTRY_CYCLES - 1)) begin
                next_r.progPending = 1'b0;
                next_r.progMode = 1'b1;
            end else begin
                next_r.progCount = r.progCount + 12'd1;
            end
        end
        if (startCond || stopCond) begin
            // A finished write transfer is acted on at its stop or repeated start
            if (r.wrOpen) begin
                if (r.wrCount == 2'd0) begin
                    if (!r.progMode && !r.progPending && !r.measBusy) begin
                        next_r.measBusy = 1'b1;
                        next_r.measCount = measCycles(r.humRes, r.tempRes);
                    end
                end else if (r.wrCount == 2'd3 && r.dataHi == 8'h00 && r.dataLo == 8'h00
                             && r.cmd == `HT_CMD_PROG_ENTER) begin
                    if (r.winCount != 24'(WINDOW_CYCLES) && !r.progMode) begin
                        next_r.progPending = 1'b1;
                        next_r.progCount = '0;
                    end
                end else if (r.wrCount == 2'd3 && r.progMode) begin
                    unique case (r.cmd)
                        `HT_CMD_PROG_EXIT: begin
                            if (r.dataHi == 8'h00 && r.dataLo == 8'h00) begin
                                next_r.progMode = 1'b0;
                            end
                        end
                        `HT_REG_HUM_RES_WR: next_r.humRes = {r.dataHi, r.dataLo};
                        `HT_REG_TEMP_RES_WR: next_r.tempRes = {r.dataHi, r.dataLo};
                        `HT_REG_HUM_RES_RD: next_r.readback = r.humRes;
                        `HT_REG_TEMP_RES_RD: next_r.readback = r.tempRes;
                        `HT_REG_ID_UPPER: next_r.readback = SENSOR_ID[31:16];
                        `HT_REG_ID_LOWER: next_r.readback = SENSOR_ID[15:0];
                        default: next_r.readback = '0;
                    endcase
                end
            end
            next_r.wrOpen = 1'b0;
            next_r.sdaDrive = 1'b0;
            next_r.bitCount = '0;
            next_r.phase = startCond ? S_ADDR : S_IDLE;
        end else begin
            unique case (r.phase)
                S_IDLE: begin
                end
                S_ADDR, S_WR_BYTE: begin
                    if (sclRise && r.bitCount != 4'd8) begin
                        next_r.shift = {r.shift[6:0], r.sdaSync};
                        next_r.bitCount = r.bitCount + 4'd1;
                    end else if (sclFall && r.bitCount == 4'd8) begin
                        if (r.phase == S_WR_BYTE) begin
                            unique case (r.wrCount)
                                2'd0: next_r.cmd = r.shift;
                                2'd1: next_r.dataHi = r.shift;
                                2'd2: next_r.dataLo = r.shift;
                                2'd3: begin
                                end
                            endcase
                            if (r.wrCount != 2'd3) begin
                                next_r.wrCount = r.wrCount + 2'd1;
                            end
                            next_r.sdaDrive = 1'b1;
                            next_r.phase = S_WR_ACK;
                        end else if (r.shift[7:1] == `HT_BUS_ADDRESS) begin
                            next_r.isRead = r.shift[0];
                            next_r.sdaDrive = 1'b1;
                            next_r.wrCount = '0;
                            next_r.byteIndex = '0;
                            next_r.phase = S_ADDR_ACK;
                        end else begin
                            next_r.phase = S_IDLE;
                        end
                    end
                end
                S_ADDR_ACK, S_WR_ACK: begin
                    if (sclFall) begin
                        if (r.phase == S_ADDR_ACK && r.isRead) begin
                            next_r.shift = nextByte;
                            next_r.sdaDrive = !nextByte[7];
                            next_r.bitCount = 4'd1;
                            next_r.byteIndex = r.byteIndex + 2'd1;
                            next_r.phase = S_RD_BYTE;
                            if (!r.progMode) begin
                                next_r.fresh = 1'b0;
                            end
                        end else begin
                            next_r.wrOpen = 1'b1;
                            next_r.sdaDrive = 1'b0;
                            next_r.bitCount = '0;
                            next_r.phase = S_WR_BYTE;
                        end
                    end
                end
                S_RD_BYTE: begin
                    if (sclFall) begin
                        if (r.bitCount == 4'd8) begin
                            next_r.sdaDrive = 1'b0;
                            next_r.phase = S_RD_ACK;
                        end else begin
                            next_r.shift = {r.shift[6:0], 1'b0};
                            next_r.sdaDrive = !r.shift[6];
                            next_r.bitCount = r.bitCount + 4'd1;
                        end
                    end
                end
                S_RD_ACK: begin
                    // bitCount of zero marks an acknowledged byte awaiting the next
                    if (sclRise) begin
                        if (r.sdaSync) begin
                            next_r.phase = S_IDLE;
                        end else begin
                            next_r.bitCount = '0;
                        end
                    end else if (sclFall && r.bitCount == 4'd0) begin
                        next_r.shift = nextByte;
                        next_r.sdaDrive = !nextByte[7];
                        next_r.bitCount = 4'd1;
                        next_r.byteIndex = r.byteIndex + 2'd1;
                        next_r.phase = S_RD_BYTE;
                    end
                end
            endcase
        end
        // Placed last: a finishing cycle beats a fetch in the same clock
        if (r.measBusy) begin
            if (r.measCount != '0) begin
                next_r.measCount = r.measCount - 24'd1;
            end else if (fifoOutValid) begin
                next_r.humidity = fifoOutData[27:14];
                next_r.temperature = fifoOutData[13:0];
                next_r.fresh = 1'b1;
                next_r.measBusy = 1'b0;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            r <= STATE_RESET;
        end else begin
            r <= next_r;
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (srst);

    sequence addrMatch;
        r.phase == S_ADDR && sclFall && r.bitCount == 4'd8 && r.shift[7:1] == `HT_BUS_ADDRESS;
    endsequence

    sequence entryWait;
        !r.progMode [*8];
    endsequence

    addr_ack_a: assert property (addrMatch |=> r.sdaDrive && r.phase == S_ADDR_ACK)
        else $error("own address not acknowledged");
    foreign_addr_a: assert property (
        (r.phase == S_ADDR && sclFall && r.bitCount == 4'd8
         && r.shift[7:1] != `HT_BUS_ADDRESS) |=> r.phase == S_IDLE && !r.sdaDrive)
        else $error("foreign address answered");
    next_byte_a: assert property (
        (r.phase == S_RD_ACK && r.bitCount == 4'd0 && sclFall) |=> r.phase == S_RD_BYTE)
        else $error("no byte after master acknowledge");
    first_byte_a: assert property (
        fetchStart |=> r.shift == {$past(statusCode), $past(r.humidity[13:8])})
        else $error("first result byte wrong");
    fetch_stale_a: assert property ((fetchStart && !measDone) |=> !r.fresh)
        else $error("fetched result still reported valid");
    result_update_a: assert property (
        measDone |=> r.fresh && !r.measBusy && r.humidity == $past(fifoOutData[27:14]))
        else $error("finished cycle did not update result");
    meas_time_a: assert property (
        $rose(r.measBusy) |-> r.measCount == measCycles(r.humRes, r.tempRes)
        && $past(startCond || stopCond) && !r.progMode)
        else $error("measurement started wrongly");
    prog_window_a: assert property (
        $rose(r.progPending) |-> $past(r.winCount) != 24'(WINDOW_CYCLES))
        else $error("programming entry outside power-up window");
    prog_entry_a: assert property ($rose(r.progPending) |-> entryWait)
        else $error("programming mode entered too early");
    prog_hold_a: assert property ((r.progMode && !r.measBusy) |=> !r.measBusy)
        else $error("measurement started in programming mode");
    res_write_a: assert property (
        $changed(r.humRes) |-> $past(r.progMode) && $past(r.cmd) == `HT_REG_HUM_RES_WR)
        else $error("humidity resolution changed without write");
    res_default_a: assert property (
        $fell(srst) |-> r.humRes == HUM_RES_INIT && r.tempRes == TEMP_RES_INIT)
        else $error("resolution defaults wrong");

endmodule // ht_readout

`default_nettype wire

// ---- ht_readout_map.svh ----
// Offsets, field positions, reset values and timing counts of the sensor readout.
// Assumes the includer runs on the 25 MHz system clock.
`ifndef HT_READOUT_MAP_SVH
`define HT_READOUT_MAP_SVH

`define HT_BUS_ADDRESS 7'h44
`define HT_CLOCK_KHZ 25000
`define HT_CYCLES(us) (((us) * `HT_CLOCK_KHZ) / 1000)

// Times in microseconds
`define HT_WAKE_US 100
`define HT_CONV8_US 550
`define HT_CONV10_US 1310
`define HT_CONV12_US 4500
`define HT_CONV14_US 16900
`define HT_PROG_WINDOW_US 10000
`define HT_PROG_ENTRY_US 120

// Commands and non-volatile register addresses
`define HT_CMD_PROG_ENTER 8'ha0
`define HT_CMD_PROG_EXIT 8'h80
`define HT_REG_HUM_RES_RD 8'h06
`define HT_REG_TEMP_RES_RD 8'h11
`define HT_REG_ID_UPPER 8'h1e
`define HT_REG_ID_LOWER 8'h1f
`define HT_REG_HUM_RES_WR 8'h46
`define HT_REG_TEMP_RES_WR 8'h51

// Resolution field and reset values
`define HT_RES_MSB 11
`define HT_RES_LSB 10
`define HT_RES_RESET 16'h0c00
`define HT_STATUS_VALID 2'h0
`define HT_STATUS_STALE 2'h1

`endif

// ---- ht_readout_pkg.sv ----
// Types shared by the sensor readout block.
// Assumes ht_readout_map.svh is compiled alongside.
package ht_readout_pkg;

    typedef enum logic [2:0] {
        S_IDLE,
        S_ADDR,
        S_ADDR_ACK,
        S_WR_BYTE,
        S_WR_ACK,
        S_RD_BYTE,
        S_RD_ACK
    } phase_e;

    typedef struct packed {
        logic sclMeta;
        logic sclSync;
        logic sclPrev;
        logic sdaMeta;
        logic sdaSync;
        logic sdaPrev;
        phase_e phase;
        logic [7:0] shift;
        logic [3:0] bitCount;
        logic isRead;
        logic wrOpen;
        logic [1:0] byteIndex;
        logic [1:0] wrCount;
        logic [7:0] cmd;
        logic [7:0] dataHi;
        logic [7:0] dataLo;
        logic sdaDrive;
        logic measBusy;
        logic [23:0] measCount;
        logic [13:0] humidity;
        logic [13:0] temperature;
        logic fresh;
        logic [23:0] winCount;
        logic progPending;
        logic [11:0] progCount;
        logic progMode;
        logic [15:0] humRes;
        logic [15:0] tempRes;
        logic [15:0] readback;
    } state_s;

endpackage

// ---- ht_sample_fifo.sv ----
// Sample FIFO between the converter and the result register.
// Assumes both sides run on the same clock; synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none

module ht_sample_fifo #(
    parameter int WIDTH = 28,
    parameter int DEPTH = 8
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int PW = $clog2(DEPTH);

    typedef struct packed {
        logic [PW-1:0] wrPtr;
        logic [PW-1:0] rdPtr;
        logic [PW:0] count;
    } fifo_s;

    fifo_s r;
    fifo_s next_r;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push;
    logic pop;

    assign inReady = (r.count != (PW+1)'(DEPTH));
    assign outValid = (r.count != '0);
    assign outData = mem[r.rdPtr];
    assign push = inValid && inReady;
    assign pop = outValid && outReady;

    always_comb begin
        next_r = r;
        if (push) begin
            next_r.wrPtr = (r.wrPtr == PW'(DEPTH - 1)) ? '0 : r.wrPtr + 1'b1;
        end
        if (pop) begin
            next_r.rdPtr = (r.rdPtr == PW'(DEPTH - 1)) ? '0 : r.rdPtr + 1'b1;
        end
        if (push && !pop) begin
            next_r.count = r.count + 1'b1;
        end else if (pop && !push) begin
            next_r.count = r.count - 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // Storage needs no reset; only the pointers and count define what is valid
    always_ff @(posedge clock) begin
        if (push) begin
            mem[r.wrPtr] <= inData;
        end
    end

endmodule // ht_sample_fifo

`default_nettype wire

// ---- i2c_master_model.sv ----
// Bus master model driving the sensor's two-wire port.
// Assumes the bench resolves the open-drain data wire with a pull-up.
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model (
    input wire logic clock,
    input wire logic sda,
    output logic scl,
    output logic sdaLow
);
    initial begin
        scl = 1'b1;
        sdaLow = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask
    task automatic start();
        sdaLow <= 1'b1;
        tick(4);
        scl <= 1'b0;
        tick(1);
    endtask
    // Low 6 clocks, high 2: device answers some 3 clocks after a fall
    task automatic xfer(input logic [8:0] d, output logic [8:0] r);
        for (int i = 8; i >= 0; i--) begin
            sdaLow <= !d[i];
            tick(5);
            scl <= 1'b1;
            tick(1);
            @(negedge clock) r[i] = sda;
            tick(1);
            scl <= 1'b0;
            tick(1);
        end
    endtask
    task automatic stop();
        sdaLow <= 1'b1;
        tick(4);
        scl <= 1'b1;
        tick(4);
        sdaLow <= 1'b0;
        tick(8);
    endtask
endmodule // i2c_master_model
`default_nettype wire

// ---- testbench.sv ----
// Bench for the sensor readout: fetch, status, NV registers, timing.
// Assumes the master model drives the pins; counts shortened.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam logic [31:0] ID = 32'h5a5a_0f0f; // Arbitrary
    // Shortened register read and write waits, in the same ratio as the real ones
    localparam int RD_WAIT = 30;
    localparam int WR_WAIT = 3500;
    logic clock = 0, srst = 1, sampleValid = 0;
    logic [13:0] hum = 0, temp = 0;
    logic scl, sdaLow, sdaOut, sdaOe, sampleReady, measuring, programmingMode;
    logic [7:0] got [5];
    int fail_count = 0, n_checks = 0, hiCount = 0;
    // Open drain with pull-up
    wire logic sda = !(sdaLow || (sdaOe && !sdaOut));
    always #20 clock = ~clock;
    always @(posedge clock) if (measuring) hiCount++;
    // Only 10 and 14 bit codes are used, so the other conversion times keep defaults
    ht_readout #(.WAKE_CYCLES(20), .CONV10_CYCLES(40),
        .CONV14_CYCLES(60), .WINDOW_CYCLES(2000), .SENSOR_ID(ID))
        i_ht_readout (.clock(clock), .srst(srst), .scl(scl), .sdaIn(sda),
        .sdaOut(sdaOut), .sdaOe(sdaOe), .sampleValid(sampleValid),
        .sampleReady(sampleReady), .sampleHumidity(hum), .sampleTemperature(temp),
        .measuring(measuring), .programmingMode(programmingMode));
    i2c_master_model i_i2c_master_model (.clock(clock), .sda(sda), .scl(scl),
        .sdaLow(sdaLow));
    task automatic chk(input logic [15:0] g, e);
        n_checks++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %0t value %h expected %h", $time, g, e);
        end
    endtask
    task automatic flag(input logic g, e);
        n_checks++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %0t flag %b expected %b", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] b0, b1, b2, input int n);
        logic [8:0] r;
        logic [7:0] b [3];
        b = '{b0, b1, b2};
        i_i2c_master_model.start();
        i_i2c_master_model.xfer({8'h88, 1'b1}, r);
        flag(r[0], 1'b0);
        for (int i = 0; i < n; i++) begin
            i_i2c_master_model.xfer({b[i], 1'b1}, r);
            flag(r[0], 1'b0);
        end
        i_i2c_master_model.stop();
    endtask
    task automatic rd(input int n);
        logic [8:0] r;
        i_i2c_master_model.start();
        i_i2c_master_model.xfer({8'h89, 1'b1}, r);
        flag(r[0], 1'b0);
        for (int i = 0; i < n; i++) begin
            i_i2c_master_model.xfer({8'hff, 1'(i == n - 1)}, r);
            got[i] = r[8:1];
        end
        i_i2c_master_model.stop();
    endtask
    task automatic reg16(input logic [7:0] a, input logic [15:0] e);
        wr(a, 8'h00, 8'h00, 3);
        repeat (RD_WAIT) @(posedge clock);
        rd(2);
        chk({got[0], got[1]}, e);
    endtask
    task automatic t_first();
        logic [8:0] r;
        rd(4);
        chk({got[0], got[1]}, 16'h4000);
        chk({got[2], got[3] & 8'hfc}, 16'h0000);
        i_i2c_master_model.start();
        i_i2c_master_model.xfer({8'h8b, 1'b1}, r);
        flag(r[0], 1'b1);
        i_i2c_master_model.stop();
    endtask
    task automatic t_prog();
        wr(8'ha0, 8'h00, 8'h00, 3);
        repeat (2900) @(posedge clock);
        flag(programmingMode, 1'b0);
        repeat (200) @(posedge clock);
        flag(programmingMode, 1'b1);
        reg16(8'h11, 16'h0c00);
        reg16(8'h1e, ID[31:16]);
        reg16(8'h1f, ID[15:0]);
        reg16(8'h06, 16'h0c00);
        wr(8'h46, got[0] & 8'hf3 | 8'h04, got[1], 3);
        repeat (WR_WAIT) @(posedge clock);
        reg16(8'h06, 16'h0400);
        reg16(8'h20, 16'h0000);
        reg16(8'h11, 16'h0c00);
        wr(8'h00, 8'h00, 8'h00, 0);
        repeat (4) @(posedge clock);
        flag(measuring, 1'b0);
        wr(8'h80, 8'h00, 8'h00, 3);
        repeat (4) @(posedge clock);
        flag(programmingMode, 1'b0);
    endtask
    // FIFO filled to refusal first, then drained one sample per cycle
    task automatic t_meas();
        for (int i = 0; i < 8; i++) begin
            hum <= 14'h2a00 + 14'(i);
            temp <= 14'h1500 + 14'(3 * i);
            sampleValid <= 1'b1;
            @(posedge clock);
        end
        sampleValid <= 1'b0;
        @(posedge clock);
        flag(sampleReady, 1'b0);
        for (int k = 0; k < 8; k++) begin
            hiCount = 0;
            wr(8'h00, 8'h00, 8'h00, 0);
            for (int w = 0; w < 400 && measuring !== 1'b0; w++) @(posedge clock);
            flag(hiCount >= 120 && hiCount <= 122, 1'b1);
            rd(5);
            chk({got[0], got[1]}, {2'b00, 14'h2a00 + 14'(k)});
            chk({got[2], got[3] & 8'hfc}, {14'h1500 + 14'(3 * k), 2'b00});
            // First sample scales to 65 percent and 14 degrees
            if (k == 0) chk(16'(({got[0][5:0], got[1]} * 100) / 16383), 16'd65);
            if (k == 0) chk(16'((({got[2], got[3][7:2]} * 165) / 16383) - 40), 16'd14);
            flag(got[4][7:6] === 2'b01, 1'b1);
        end
        flag(sampleReady, 1'b1);
        rd(2);
        flag(got[0][7:6] === 2'b01, 1'b1);
    endtask
    task automatic t_late();
        wr(8'ha0, 8'h00, 8'h00, 3);
        repeat (3100) @(posedge clock);
        flag(programmingMode, 1'b0);
    endtask
    task automatic results();
        if (fail_count == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clock);
        srst <= 1'b0;
        repeat (4) @(posedge clock);
        t_first();
        t_prog();
        t_meas();
        t_late();
        results();
    end
    // Run needs about 21000 cycles
    initial begin
        repeat (40000) @(posedge clock);
        fail_count++;
        results();
    end
endmodule // testbench
`default_nettype wire
